// file: gpp_port.sv
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/1ps
// How it works
// RL1 - every reset loads the port 0 output data register with all ones.
// RL2 - every reset loads the port 1 output data register with 0x7f, bit 7 clear.
// RL3 - port 0 output data bits drive output pins and pick the pull-up for input pins.
// RL4 - port 1 output data bits 6 to 0 play the same two roles.
// RL5 - software writes update the output data registers and reads return them exactly.
// RL6 - changing pin direction leaves the output data registers untouched.
// RL7 - bit 7 of the port 1 output data register always reads zero.
// RL8 - the reset input on port 1 pin 6 stays live until software sets the disable bit.
// RL9 - while live, pulling port 1 pin 6 low by its own drive causes a device reset.
// RL10 - reads of the port 0 input register return the pin levels and writes do nothing.
// RL11 - the port 0 input register follows sampled pins after reset, not a constant.
// RL12 - an input pin whose output data bit is one has its weak pull-up on.
// RL13 - an input pin whose output data bit is zero has no pull-up and floats.
// RL14 - a per-pin direction bit enables the pin driver for output and disables it for input.
module gpp_port (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // avalon-mm slave
  input wire logic [gpp_pkg::GPP_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output gpp_pkg::gpp_bus_out_type avs_out,
  // package pins
  input wire logic [7:0] p0_in,
  input wire logic [6:0] p1_in,
  output gpp_pkg::gpp_pin_out_type pins_out,
  // reset request to the reset controller
  output logic ext_reset_req
);

  // all state of the block
  typedef struct packed {
    gpp_pkg::gpp_bus_type bus;
    gpp_pkg::gpp_bus_out_type bus_out;
    logic [7:0] po0;
    logic [7:0] po1;
    logic [7:0] dir0;
    logic [7:0] dir1;
    logic rst_dis;
    logic [7:0] pi0;
    logic [6:0] pi1;
    gpp_pkg::gpp_pin_out_type pins;
    logic ext_rst;
  } gpp_state_type;

  gpp_state_type state_r;
  gpp_state_type state_nxt;

  // address decode, shared by the read and write paths
  function automatic gpp_pkg::gpp_sel_type gpp_decode(
    input logic [gpp_pkg::GPP_ADDR_W-1:0] addr
  );
    logic [3:0] idx;
    idx = addr[gpp_pkg::GPP_ADDR_W-1:2];
    if (addr[1:0] != 2'h0) begin
      gpp_decode = gpp_pkg::GPP_SEL_NONE;
    end else if (idx == gpp_pkg::GPP_IDX_PORT0_OUTPUT_DATA) begin
      gpp_decode = gpp_pkg::GPP_SEL_PO0;
    end else if (idx == gpp_pkg::GPP_IDX_PORT1_OUTPUT_DATA) begin
      gpp_decode = gpp_pkg::GPP_SEL_PO1;
    end else if (idx == gpp_pkg::GPP_IDX_PORT0_PIN_INPUT) begin
      gpp_decode = gpp_pkg::GPP_SEL_PI0;
    end else if (idx == gpp_pkg::GPP_IDX_PORT0_DIRECTION) begin
      gpp_decode = gpp_pkg::GPP_SEL_DIR0;
    end else if (idx == gpp_pkg::GPP_IDX_PORT1_DIRECTION) begin
      gpp_decode = gpp_pkg::GPP_SEL_DIR1;
    end else if (idx == gpp_pkg::GPP_IDX_RESET_CONTROL) begin
      gpp_decode = gpp_pkg::GPP_SEL_RCTL;
    end else begin
      gpp_decode = gpp_pkg::GPP_SEL_NONE;
    end
  endfunction : gpp_decode

  gpp_pkg::gpp_sel_type sel;
  logic [7:0] rd_byte;
  logic wr_en;
  logic [7:0] wr_byte;

  // next state
  always_comb begin
    state_nxt = state_r;
    sel = gpp_decode(avs_address);
    wr_byte = avs_writedata[7:0];
    wr_en = (state_r.bus == gpp_pkg::GPP_BUS_ACK) && avs_write && avs_byteenable[0];
    rd_byte = 8'h00;
    // read mux
    case (sel)
      gpp_pkg::GPP_SEL_PO0: rd_byte = state_r.po0; // [RL5]
      gpp_pkg::GPP_SEL_PO1: rd_byte = state_r.po1 & gpp_pkg::GPP_PORT1_MASK; // [RL7]
      gpp_pkg::GPP_SEL_PI0: rd_byte = state_r.pi0; // [RL10]
      gpp_pkg::GPP_SEL_DIR0: rd_byte = state_r.dir0;
      gpp_pkg::GPP_SEL_DIR1: rd_byte = state_r.dir1 & gpp_pkg::GPP_PORT1_MASK;
      gpp_pkg::GPP_SEL_RCTL: begin
        rd_byte[gpp_pkg::GPP_RCTL_DISABLE_BIT] = state_r.rst_dis;
        rd_byte[gpp_pkg::GPP_RCTL_REQ_BIT] = state_r.ext_rst;
      end
      default: rd_byte = 8'h00;
    endcase
    // handshake: one wait cycle, then the answer
    case (state_r.bus)
      gpp_pkg::GPP_BUS_IDLE: begin
        if (avs_read || avs_write) begin
          state_nxt.bus = gpp_pkg::GPP_BUS_ACK;
          state_nxt.bus_out.waitrequest = 1'b0;
          state_nxt.bus_out.readdata = avs_read ? {24'h000000, rd_byte} : 32'h00000000;
          state_nxt.bus_out.response = (sel == gpp_pkg::GPP_SEL_NONE) ?
            gpp_pkg::GPP_RESP_SLVERR : gpp_pkg::GPP_RESP_OKAY;
        end
      end
      gpp_pkg::GPP_BUS_ACK: begin
        state_nxt.bus = gpp_pkg::GPP_BUS_IDLE;
        state_nxt.bus_out.waitrequest = 1'b1;
      end
      default: state_nxt.bus = gpp_pkg::GPP_BUS_IDLE;
    endcase
    // register writes; direction writes never touch data
    if (wr_en) begin
      case (sel)
        gpp_pkg::GPP_SEL_PO0: state_nxt.po0 = wr_byte; // [RL5]
        gpp_pkg::GPP_SEL_PO1: state_nxt.po1 = wr_byte & gpp_pkg::GPP_PORT1_MASK; // [RL5] [RL7]
        gpp_pkg::GPP_SEL_DIR0: state_nxt.dir0 = wr_byte; // [RL6]
        gpp_pkg::GPP_SEL_DIR1: state_nxt.dir1 = wr_byte & gpp_pkg::GPP_PORT1_MASK; // [RL6]
        gpp_pkg::GPP_SEL_RCTL: state_nxt.rst_dis = wr_byte[gpp_pkg::GPP_RCTL_DISABLE_BIT];
        default: state_nxt.rst_dis = state_r.rst_dis; // input register ignores writes [RL10]
      endcase
    end
    // pin sampling every cycle
    state_nxt.pi0 = p0_in; // [RL10] [RL11]
    state_nxt.pi1 = p1_in;
    // pin drive: data, driver enable and pull-up follow the new register values
    state_nxt.pins.p0_out = state_nxt.po0; // [RL3]
    state_nxt.pins.p0_oe = state_nxt.dir0; // [RL14]
    state_nxt.pins.p0_pullup = ~state_nxt.dir0 & state_nxt.po0; // [RL3] [RL12] [RL13]
    state_nxt.pins.p1_out = state_nxt.po1[6:0]; // [RL4]
    state_nxt.pins.p1_oe = state_nxt.dir1[6:0]; // [RL14]
    state_nxt.pins.p1_pullup = ~state_nxt.dir1[6:0] & state_nxt.po1[6:0]; // [RL4] [RL12] [RL13]
    // reset input on port 1 pin 6, also reached by the port's own drive
    state_nxt.ext_rst = ~state_r.rst_dis & ~p1_in[gpp_pkg::GPP_P1_RST_PIN]; // [RL8] [RL9]
  end

  // state register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r.bus <= gpp_pkg::GPP_BUS_IDLE;
      state_r.bus_out.waitrequest <= 1'b1;
      state_r.bus_out.readdata <= 32'h00000000;
      state_r.bus_out.response <= gpp_pkg::GPP_RESP_OKAY;
      state_r.po0 <= gpp_pkg::GPP_PORT0_OUT_RST; // [RL1]
      state_r.po1 <= gpp_pkg::GPP_PORT1_OUT_RST; // [RL2]
      state_r.dir0 <= gpp_pkg::GPP_DIR_RST;
      state_r.dir1 <= gpp_pkg::GPP_DIR_RST;
      state_r.rst_dis <= 1'b0; // [RL8]
      state_r.pi0 <= 8'h00;
      state_r.pi1 <= 7'h00;
      state_r.pins.p0_out <= gpp_pkg::GPP_PORT0_OUT_RST;
      state_r.pins.p0_oe <= gpp_pkg::GPP_DIR_RST;
      state_r.pins.p0_pullup <= gpp_pkg::GPP_PORT0_OUT_RST;
      state_r.pins.p1_out <= gpp_pkg::GPP_PORT1_OUT_RST[6:0];
      state_r.pins.p1_oe <= gpp_pkg::GPP_DIR_RST[6:0];
      state_r.pins.p1_pullup <= gpp_pkg::GPP_PORT1_OUT_RST[6:0];
      state_r.ext_rst <= 1'b0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // outputs straight from the state register
  assign avs_out = state_r.bus_out;
  assign pins_out = state_r.pins;
  assign ext_reset_req = state_r.ext_rst;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  logic req_idle;
  assign req_idle = (avs_read || avs_write) && (state_r.bus == gpp_pkg::GPP_BUS_IDLE);

  sequence req_seen_s;
    req_idle;
  endsequence

  sequence one_wait_answer_s;
    !avs_out.waitrequest ##1 avs_out.waitrequest;
  endsequence

  bus_handshake_a: assert property (req_seen_s |=> one_wait_answer_s) // [RL5]
    else $error("answer not given after exactly one wait cycle");

  po0_reset_a: assert property ($rose(rstn) |-> state_r.po0 == gpp_pkg::GPP_PORT0_OUT_RST) // [RL1]
    else $error("port 0 data not all ones after reset");

  po1_reset_a: assert property ($rose(rstn) |-> state_r.po1 == gpp_pkg::GPP_PORT1_OUT_RST) // [RL2]
    else $error("port 1 data not 0x7f after reset");

  po0_write_a: assert property (wr_en && sel == gpp_pkg::GPP_SEL_PO0 |=>
    pins_out.p0_out == $past(avs_writedata[7:0])) // [RL3]
    else $error("port 0 pins do not show written data");

  po0_readback_a: assert property (req_idle && avs_read && sel == gpp_pkg::GPP_SEL_PO0 |=>
    avs_out.readdata[7:0] == $past(state_r.po0)) // [RL5]
    else $error("port 0 data read back wrong");

  po1_bit7_a: assert property (req_idle && avs_read && sel == gpp_pkg::GPP_SEL_PO1 |=>
    !avs_out.readdata[7] && avs_out.readdata[6:0] == $past(state_r.po1[6:0])) // [RL7]
    else $error("port 1 data read back wrong or bit 7 set");

  dir_keeps_data_a: assert property (wr_en && sel == gpp_pkg::GPP_SEL_DIR1 |=>
    $stable(state_r.po1) && pins_out.p1_oe == $past(avs_writedata[6:0])) // [RL6] [RL14]
    else $error("direction write disturbed data or missed driver enable");

  pi0_follow_a: assert property ($past(rstn) |-> state_r.pi0 == $past(p0_in)) // [RL10] [RL11]
    else $error("port 0 input register does not follow pins");

  reset_pin_a: assert property (!state_r.rst_dis && !p1_in[gpp_pkg::GPP_P1_RST_PIN] |=>
    ext_reset_req) // [RL8] [RL9]
    else $error("low reset pin did not request reset");

  reset_disable_a: assert property (state_r.rst_dis |=> !ext_reset_req) // [RL8]
    else $error("reset requested while disabled");

  pullup_on_a: assert property (!pins_out.p0_oe[0] && pins_out.p0_out[0] |->
    pins_out.p0_pullup[0]) // [RL12]
    else $error("input pin with data one has no pull-up");

  pullup_off_a: assert property (!pins_out.p1_oe[0] && !pins_out.p1_out[0] |->
    !pins_out.p1_pullup[0]) // [RL13]
    else $error("input pin with data zero kept its pull-up");

  // live reset input seeing a low level on port 1 pin 6
  logic pin6_low_live;
  assign pin6_low_live = !state_r.rst_dis && !p1_in[gpp_pkg::GPP_P1_RST_PIN];

  // a read taken while idle, and a write landing in the answer cycle
  sequence read_taken_s;
    req_idle && avs_read;
  endsequence

  sequence write_lands_s;
    wr_en;
  endsequence

  // a direction write for port 0 reaches the driver enables, not the data
  dir0_write_a: assert property (write_lands_s and sel == gpp_pkg::GPP_SEL_DIR0 |=>
    $stable(state_r.po0) && pins_out.p0_oe == $past(avs_writedata[7:0])) // [RL6] [RL14]
    else $error("port 0 direction write disturbed data or missed enable");

  // a port 1 data write shows on the port 1 pins
  po1_write_a: assert property (write_lands_s and sel == gpp_pkg::GPP_SEL_PO1 |=>
    pins_out.p1_out == $past(avs_writedata[6:0])) // [RL4]
    else $error("port 1 pins do not show written data");

  // a write to the input register leaves port 0 data and direction unchanged
  pi0_no_write_a: assert property (write_lands_s and sel == gpp_pkg::GPP_SEL_PI0 |=>
    $stable(state_r.po0) && $stable(state_r.dir0)) // [RL10]
    else $error("write to input register changed state");

  // port 0 pull-ups only on input pins whose data bit is one
  p0_pullup_eq_a: assert property (pins_out.p0_pullup == (~pins_out.p0_oe & pins_out.p0_out))
    else $error("port 0 pull-up pattern wrong"); // [RL3] [RL12] [RL13]

  // port 1 pull-ups only on input pins whose data bit is one
  p1_pullup_eq_a: assert property (pins_out.p1_pullup == (~pins_out.p1_oe & pins_out.p1_out))
    else $error("port 1 pull-up pattern wrong"); // [RL4] [RL12] [RL13]

  // port 0 driver enables follow the direction bits
  p0_oe_dir_a: assert property (pins_out.p0_oe == state_r.dir0) // [RL14]
    else $error("port 0 driver enable differs from direction");

  // port 1 driver enables follow the direction bits
  p1_oe_dir_a: assert property (pins_out.p1_oe == state_r.dir1[6:0]) // [RL14]
    else $error("port 1 driver enable differs from direction");

  // port 0 drive level is the stored data
  p0_out_data_a: assert property (pins_out.p0_out == state_r.po0) // [RL3]
    else $error("port 0 drive level differs from data");

  // port 1 drive level is the stored data
  p1_out_data_a: assert property (pins_out.p1_out == state_r.po1[6:0]) // [RL4]
    else $error("port 1 drive level differs from data");

  // the reserved data bit of port 1 is never stored
  po1_reserved_a: assert property (!state_r.po1[7]) // [RL7]
    else $error("port 1 data bit 7 set");

  // the unused direction bit of port 1 is never stored
  dir1_reserved_a: assert property (!state_r.dir1[7])
    else $error("port 1 direction bit 7 set");

  // answers carry one byte, upper bits zero
  upper_zero_a: assert property (!avs_out.waitrequest |-> avs_out.readdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");

  // a write only lands while the answer is shown
  write_ack_a: assert property (wr_en |-> !avs_out.waitrequest) // [RL5]
    else $error("write landed outside the answer cycle");

  // the answer stands a single cycle
  single_wait_a: assert property (!avs_out.waitrequest |=> avs_out.waitrequest)
    else $error("waitrequest low for more than one cycle");

  // unmapped addresses answer with a slave error
  resp_unmapped_a: assert property (req_idle && sel == gpp_pkg::GPP_SEL_NONE |=>
    avs_out.response == gpp_pkg::GPP_RESP_SLVERR)
    else $error("unmapped access not answered with an error");

  // mapped addresses answer okay
  resp_mapped_a: assert property (req_idle && sel != gpp_pkg::GPP_SEL_NONE |=>
    avs_out.response == gpp_pkg::GPP_RESP_OKAY)
    else $error("mapped access answered with an error");

  // the disable bit reads back as stored
  rctl_readback_a: assert property (read_taken_s and sel == gpp_pkg::GPP_SEL_RCTL |=>
    avs_out.readdata[gpp_pkg::GPP_RCTL_DISABLE_BIT] == $past(state_r.rst_dis)) // [RL8]
    else $error("reset disable bit read back wrong");

  // the input register reads back the sampled pins
  pi0_readback_a: assert property (read_taken_s and sel == gpp_pkg::GPP_SEL_PI0 |=>
    avs_out.readdata[7:0] == $past(state_r.pi0)) // [RL10]
    else $error("port 0 input register read back wrong");

  // port 0 data only changes by its own write
  po0_hold_a: assert property (!(wr_en && sel == gpp_pkg::GPP_SEL_PO0) |=>
    $stable(state_r.po0)) // [RL5] [RL6]
    else $error("port 0 data changed without a write");

  // port 1 data only changes by its own write
  po1_hold_a: assert property (!(wr_en && sel == gpp_pkg::GPP_SEL_PO1) |=>
    $stable(state_r.po1)) // [RL5] [RL6]
    else $error("port 1 data changed without a write");

  // a reset request always has a live low pin behind it
  ext_req_cause_a: assert property (ext_reset_req |-> $past(pin6_low_live)) // [RL9]
    else $error("reset requested without a low live pin");

  // no request without a live low pin
  ext_req_quiet_a: assert property (!pin6_low_live |=> !ext_reset_req) // [RL8]
    else $error("reset requested while pin high or disabled");

endmodule : gpp_port

// file: gpp_pkg.sv
package gpp_pkg;

  // bus geometry
  localparam int GPP_ADDR_W = 6;
  localparam int GPP_DATA_W = 32;
  localparam int GPP_P0_W = 8;
  localparam int GPP_P1_W = 7;
  localparam int GPP_P1_RST_PIN = 6;

  // register indices; byte address is four times the index
  localparam logic [3:0] GPP_IDX_PORT0_OUTPUT_DATA = 4'h0;
  localparam logic [3:0] GPP_IDX_PORT1_OUTPUT_DATA = 4'h1;
  localparam logic [3:0] GPP_IDX_PORT0_PIN_INPUT = 4'h2;
  localparam logic [3:0] GPP_IDX_PORT0_DIRECTION = 4'h8;
  localparam logic [3:0] GPP_IDX_PORT1_DIRECTION = 4'h9;
  localparam logic [3:0] GPP_IDX_RESET_CONTROL = 4'ha;

  // reset values
  localparam logic [7:0] GPP_PORT0_OUT_RST = 8'hff;
  localparam logic [7:0] GPP_PORT1_OUT_RST = 8'h7f;
  localparam logic [7:0] GPP_DIR_RST = 8'h00;
  localparam logic [7:0] GPP_PORT1_MASK = 8'h7f;

  // reset control field positions
  localparam int GPP_RCTL_DISABLE_BIT = 0;
  localparam int GPP_RCTL_REQ_BIT = 1;

  // avalon response codes
  localparam logic [1:0] GPP_RESP_OKAY = 2'h0;
  localparam logic [1:0] GPP_RESP_SLVERR = 2'h2;

  // decoded register select
  typedef enum logic [2:0] {
    GPP_SEL_NONE = 3'b000,
    GPP_SEL_PO0 = 3'b001,
    GPP_SEL_PO1 = 3'b010,
    GPP_SEL_PI0 = 3'b011,
    GPP_SEL_DIR0 = 3'b100,
    GPP_SEL_DIR1 = 3'b101,
    GPP_SEL_RCTL = 3'b110
  } gpp_sel_type;

  // bus handshake phases
  typedef enum logic [0:0] {
    GPP_BUS_IDLE = 1'b0,
    GPP_BUS_ACK = 1'b1
  } gpp_bus_type;

  // pin side outputs
  typedef struct packed {
    logic [7:0] p0_out;
    logic [7:0] p0_oe;
    logic [7:0] p0_pullup;
    logic [6:0] p1_out;
    logic [6:0] p1_oe;
    logic [6:0] p1_pullup;
  } gpp_pin_out_type;

  // avalon slave answer
  typedef struct packed {
    logic waitrequest;
    logic [31:0] readdata;
    logic [1:0] response;
  } gpp_bus_out_type;

endpackage : gpp_pkg

// file: gpp_pins.sv
`timescale 1ns/1ps
module gpp_pins (
  // drive from the port
  input wire gpp_pkg::gpp_pin_out_type pins,
  // board level on pins with no driver and no pull-up
  input wire logic [7:0] ext0,
  input wire logic [6:0] ext1,
  // resolved pin levels
  output logic [7:0] p0_in,
  output logic [6:0] p1_in
);
  // driver wins, then the weak pull-up, then the board level
  assign p0_in = (pins.p0_oe & pins.p0_out) | (~pins.p0_oe & (pins.p0_pullup | ext0));
  assign p1_in = (pins.p1_oe & pins.p1_out) | (~pins.p1_oe & (pins.p1_pullup | ext1));
endmodule : gpp_pins

// file: tb.sv
`timescale 1ns/1ps
module tb;
  typedef struct packed {logic w; logic [3:0] i; logic [7:0] d; logic [7:0] e;} gpp_row_type;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic rstn;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  gpp_pkg::gpp_bus_out_type avs_out;
  gpp_pkg::gpp_pin_out_type pins_out;
  logic [7:0] p0_in;
  logic [6:0] p1_in;
  logic ext_reset_req;
  logic [31:0] q;
  logic [1:0] rsp;
  int errors = 0;
  int cmp_count = 0;
  logic ext_ok_r = 1'b1;
  // write flag, index, data, expected read
  localparam gpp_row_type rows [14] = '{
    '{1'b0, 4'h0, 8'h00, 8'hff}, '{1'b0, 4'h1, 8'h00, 8'h7f},
    '{1'b0, 4'h2, 8'h00, 8'hff}, '{1'b1, 4'h0, 8'ha5, 8'h00},
    '{1'b0, 4'h0, 8'h00, 8'ha5}, '{1'b0, 4'h2, 8'h00, 8'hf5},
    '{1'b1, 4'h2, 8'h00, 8'h00}, '{1'b0, 4'h2, 8'h00, 8'hf5},
    '{1'b1, 4'h1, 8'hff, 8'h00}, '{1'b0, 4'h1, 8'h00, 8'h7f},
    '{1'b1, 4'h8, 8'h0f, 8'h00}, '{1'b0, 4'h0, 8'h00, 8'ha5},
    '{1'b1, 4'h0, 8'h0a, 8'h00}, '{1'b0, 4'h2, 8'h00, 8'h5a}
  };
  // the reset request of the block resets it through the system
  assign rstn = rst_n & ext_ok_r;
  always @(posedge clk) ext_ok_r <= ~ext_reset_req;
  // clock
  always #50 clk = ~clk;
  gpp_port gpp_port_inst (
    .clk(clk), .rstn(rstn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'h1), .avs_out(avs_out),
    .p0_in(p0_in), .p1_in(p1_in), .pins_out(pins_out),
    .ext_reset_req(ext_reset_req)
  );
  gpp_pins gpp_pins_inst (
    .pins(pins_out), .ext0(8'h50), .ext1(7'h55), .p0_in(p0_in), .p1_in(p1_in)
  );
  // one transfer, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] i, input logic [7:0] d);
    avs_address <= {i, 2'b00};
    avs_writedata <= {24'h000000, d};
    avs_write <= w;
    avs_read <= ~w;
    do begin
      @(posedge clk);
    end while (avs_out.waitrequest !== 1'b0);
    q = avs_out.readdata;
    rsp = avs_out.response;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask : bus
  // compare one value
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  // verdict and end of run
  task automatic conclude();
    $display("comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude
  // watchdog
  initial begin
    repeat (3000) @(posedge clk);
    errors++;
    conclude();
  end
  // main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    foreach (rows[k]) begin
      bus(rows[k].w, rows[k].i, rows[k].d);
      if (!rows[k].w) chk("readdata", {24'h0, rows[k].e}, q);
      chk("response", {30'h0, gpp_pkg::GPP_RESP_OKAY}, {30'h0, rsp});
    end
    chk("p0_oe", 32'h0f, {24'h0, pins_out.p0_oe});
    chk("p0_out", 32'h0a, {24'h0, pins_out.p0_out});
    chk("p0_pullup", 32'h00, {24'h0, pins_out.p0_pullup});
    // unmapped index
    bus(1'b0, 4'h3, 8'h00);
    chk("unmapped data", 32'h0, q);
    chk("unmapped resp", {30'h0, gpp_pkg::GPP_RESP_SLVERR}, {30'h0, rsp});
    // drive port 1 pin 6 low while the reset input is live
    bus(1'b1, 4'h9, 8'h40);
    bus(1'b1, 4'h1, 8'h3f);
    repeat (4) @(posedge clk);
    bus(1'b0, 4'h0, 8'h00);
    chk("po0 after pin reset", 32'hff, q);
    bus(1'b0, 4'h1, 8'h00);
    chk("po1 after pin reset", 32'h7f, q);
    chk("p1_pullup", 32'h7f, {25'h0, pins_out.p1_pullup});
    // same drive with the reset input disabled
    bus(1'b1, 4'ha, 8'h01);
    bus(1'b1, 4'h0, 8'h33);
    bus(1'b1, 4'h9, 8'h40);
    bus(1'b1, 4'h1, 8'h3f);
    repeat (4) @(posedge clk);
    chk("reset request", 32'h0, {31'h0, ext_reset_req});
    bus(1'b0, 4'h0, 8'h00);
    chk("po0 kept", 32'h33, q);
    bus(1'b0, 4'ha, 8'h00);
    chk("reset control", 32'h01, q);
    chk("p1_out", 32'h3f, {25'h0, pins_out.p1_out});
    chk("p1_oe", 32'h40, {25'h0, pins_out.p1_oe});
    conclude();
  end
endmodule : tb
